// ### src/baeu_consts.vh
// constants for the bit and arithmetic execution unit
`ifndef BAEU_CONSTS_VH
`define BAEU_CONSTS_VH
// operation codes presented by decode
`define BAEU_OP_NOP 4'h0
`define BAEU_OP_ADD_IMM 4'h1
`define BAEU_OP_ADD_C_IMM 4'h2
`define BAEU_OP_SUB_IND 4'h3
`define BAEU_OP_ROR_C 4'h4
`define BAEU_OP_ROL_C 4'h5
`define BAEU_OP_CMP_BNE 4'h6
`define BAEU_OP_BIT_ONE 4'h7
`define BAEU_OP_BIT_ZERO 4'h8
`define BAEU_OP_BIT_INV 4'h9
`define BAEU_OP_JMP_HI 4'ha
`define BAEU_OP_JMP_LO 4'hb
`define BAEU_OP_JMP_HI_ZERO 4'hc
`define BAEU_OP_C_ONE 4'hd
`define BAEU_OP_C_ZERO 4'he
`define BAEU_OP_C_INV 4'hf
// bit moves use the mode input on a nop code
`define BAEU_MV_NONE 2'h0
`define BAEU_MV_TO_C 2'h1
`define BAEU_MV_FROM_C 2'h2
// instruction lengths in bytes
`define BAEU_LEN_ONE 2'h1
`define BAEU_LEN_TWO 2'h2
`define BAEU_LEN_THREE 2'h3
// reset values
`define BAEU_ACC_RST 8'h00
`define BAEU_PC_RST 16'h0000
`endif

// ### src/baeu_adder.v
// eight bit adder with carry in, carry out and subtract mode
`timescale 1ns/1ns
module baeu_adder (
  // operands
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  input wire sub,
  // result
  output wire [7:0] sum,
  output wire cout
);
  wire [8:0] total;
  // subtract is a plus inverted b plus inverted borrow
  assign total = {1'b0, a} + {1'b0, (sub ? ~b : b)} + {8'h00, cin ^ sub};
  assign sum = total[7:0];
  // borrow out is the inverted carry out
  assign cout = total[8] ^ sub;
endmodule // baeu_adder

// ### src/baeu_exec.v
// execution unit for accumulator arithmetic, rotates and bit operations
//
// Summary of operation
// - add immediate to accumulator, plain or with carry; two bytes, one cycle
// - subtract indirect ram byte and borrow from accumulator; one byte, one cycle
// - rotate accumulator right through carry as nine bit ring; one cycle
// - rotate accumulator left through carry as nine bit ring; one cycle
// - compare indirect byte with immediate, branch if unequal; three bytes
// - set, clear, complement any direct bit with single opcodes
// - jump on bit high or low accepts any direct bit address
// - jump if bit set then clear it, in two cycles
// - branches add signed final byte to incremented pc; two cycles
// - one byte set, clear, complement act on carry itself
// - bit to carry in one cycle, carry to bit in two cycles
`timescale 1ns/1ns
`include "baeu_consts.vh"
module baeu_exec (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // decoded instruction, one cycle strobe
  input wire start,
  input wire [3:0] opcode,
  input wire [1:0] move_mode,
  input wire [7:0] operand,
  input wire [7:0] rel,
  // immediate that compare_branch_unequal tests the ram byte against
  input wire [7:0] cmp_imm,
  input wire [15:0] pc_in,
  // bit operand read from the bit space
  input wire bit_in,
  // results
  output reg [7:0] acc,
  output reg carry,
  output reg busy,
  output reg done,
  output reg [1:0] length,
  output reg [15:0] pc_next,
  output reg branch_taken,
  output reg bit_we,
  output reg bit_out
);
  ////////////////////////////////////////////////////////////////////////
  // state machine
  localparam ST_IDLE = 2'b01;
  localparam ST_SECOND = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  // what the second cycle of a two-cycle op retires, captured at start
  // so the decode inputs may change while busy is high
  reg pend_branch;
  reg pend_bit_we;
  reg pend_bit_val;
  reg [15:0] pend_pc;
  wire is_sub;
  wire add_cin;
  wire [7:0] add_sum;
  wire add_cout;
  wire [15:0] pc_inc;
  wire [15:0] pc_rel;
  // arithmetic shares one adder; subtract only has the indirect form
  // compare runs ram byte minus immediate, so carry ends as the borrow
  assign is_sub = (opcode == `BAEU_OP_SUB_IND) |
                  (opcode == `BAEU_OP_CMP_BNE);
  assign add_cin = (opcode == `BAEU_OP_ADD_C_IMM) |
                   (opcode == `BAEU_OP_SUB_IND) ? carry : 1'b0;
  baeu_adder u_adder (
    .a(opcode == `BAEU_OP_CMP_BNE ? operand : acc),
    .b(opcode == `BAEU_OP_CMP_BNE ? cmp_imm : operand),
    .cin(add_cin),
    .sub(is_sub),
    .sum(add_sum),
    .cout(add_cout)
  );
  // pc after fetch of the whole instruction, then signed displacement;
  // both wrap at 16 bits, as the program counter itself does
  assign pc_inc = pc_in + {14'h0000, length_of(opcode, move_mode)};
  assign pc_rel = pc_inc + {{8{rel[7]}}, rel};
  // byte count of each instruction; bit moves carry a bit address
  function [1:0] length_of;
    input [3:0] op;
    input [1:0] mv;
    begin
      case (op)
        `BAEU_OP_ADD_IMM, `BAEU_OP_ADD_C_IMM:
          length_of = `BAEU_LEN_TWO;
        `BAEU_OP_SUB_IND, `BAEU_OP_ROR_C, `BAEU_OP_ROL_C,
        `BAEU_OP_C_ONE, `BAEU_OP_C_ZERO, `BAEU_OP_C_INV:
          length_of = `BAEU_LEN_ONE;
        `BAEU_OP_CMP_BNE, `BAEU_OP_JMP_HI, `BAEU_OP_JMP_LO,
        `BAEU_OP_JMP_HI_ZERO: length_of = `BAEU_LEN_THREE;
        `BAEU_OP_NOP: length_of = (mv == `BAEU_MV_NONE) ? `BAEU_LEN_ONE :
                                  `BAEU_LEN_TWO;
        default: length_of = `BAEU_LEN_TWO;
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // next state: branches and carry to bit stores take a second cycle
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start && ((opcode == `BAEU_OP_CMP_BNE) ||
            (opcode == `BAEU_OP_JMP_HI) || (opcode == `BAEU_OP_JMP_LO) ||
            (opcode == `BAEU_OP_JMP_HI_ZERO) ||
            (opcode == `BAEU_OP_NOP && move_mode == `BAEU_MV_FROM_C))) begin
          next_state = ST_SECOND;
        end
      end
      ST_SECOND: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // execution; a start while busy is ignored
  // the retiring edge still sees busy high, so decode must wait for done
  // before the next request; nothing flags a dropped start
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      acc <= `BAEU_ACC_RST;
      carry <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      length <= `BAEU_LEN_ONE;
      pc_next <= `BAEU_PC_RST;
      branch_taken <= 1'b0;
      bit_we <= 1'b0;
      bit_out <= 1'b0;
      pend_branch <= 1'b0;
      pend_bit_we <= 1'b0;
      pend_bit_val <= 1'b0;
      pend_pc <= `BAEU_PC_RST;
    end else begin
      state <= next_state;
      done <= 1'b0;
      bit_we <= 1'b0;
      branch_taken <= 1'b0;
      if (state == ST_SECOND) begin
        // second cycle retires the pending branch or store
        busy <= 1'b0;
        done <= 1'b1;
        branch_taken <= pend_branch;
        pc_next <= pend_pc;
        bit_we <= pend_bit_we;
        bit_out <= pend_bit_val;
      end else if (start) begin
        length <= length_of(opcode, move_mode);
        pend_branch <= 1'b0;
        pend_bit_we <= 1'b0;
        pend_bit_val <= 1'b0;
        pend_pc <= pc_inc;
        if (next_state == ST_SECOND) begin
          busy <= 1'b1;
        end else begin
          done <= 1'b1;
          pc_next <= pc_inc;
        end
        case (opcode)
          `BAEU_OP_ADD_IMM, `BAEU_OP_ADD_C_IMM, `BAEU_OP_SUB_IND: begin
            acc <= add_sum;
            carry <= add_cout;
          end
          `BAEU_OP_ROR_C: begin
            acc <= {carry, acc[7:1]};
            carry <= acc[0];
          end
          `BAEU_OP_ROL_C: begin
            acc <= {acc[6:0], carry};
            carry <= acc[7];
          end
          `BAEU_OP_CMP_BNE: begin
            // operand is the ram byte, cmp_imm the immediate, rel the offset
            carry <= add_cout;
            pend_branch <= (add_sum != 8'h00);
            pend_pc <= (add_sum != 8'h00) ? pc_rel : pc_inc;
          end
          `BAEU_OP_BIT_ONE: begin
            bit_we <= 1'b1;
            bit_out <= 1'b1;
          end
          `BAEU_OP_BIT_ZERO: begin
            bit_we <= 1'b1;
            bit_out <= 1'b0;
          end
          `BAEU_OP_BIT_INV: begin
            bit_we <= 1'b1;
            bit_out <= ~bit_in;
          end
          `BAEU_OP_JMP_HI, `BAEU_OP_JMP_LO: begin
            // any bit address; source bit is only read
            pend_branch <= bit_in ^ (opcode == `BAEU_OP_JMP_LO);
            pend_pc <= (bit_in ^ (opcode == `BAEU_OP_JMP_LO)) ?
                       pc_rel : pc_inc;
          end
          `BAEU_OP_JMP_HI_ZERO: begin
            // the clear is staged so it lands together with the branch
            pend_branch <= bit_in;
            pend_pc <= bit_in ? pc_rel : pc_inc;
            pend_bit_we <= bit_in;
            pend_bit_val <= 1'b0;
          end
          // carry-only forms need no bit address
          `BAEU_OP_C_ONE: carry <= 1'b1;
          `BAEU_OP_C_ZERO: carry <= 1'b0;
          `BAEU_OP_C_INV: carry <= ~carry;
          default: begin
            // nop code: move mode picks bit to carry or carry to bit
            if (move_mode == `BAEU_MV_TO_C) begin
              carry <= bit_in;
            end else if (move_mode == `BAEU_MV_FROM_C) begin
              pend_bit_we <= 1'b1;
              pend_bit_val <= carry;
            end
          end
        endcase
      end
    end
  end
endmodule // baeu_exec

// ### verif/baeu_exec_props.sv
// assertion checker on the execution unit ports
`timescale 1ns/1ns
`include "baeu_consts.vh"
module baeu_exec_props (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // request side
  input wire start,
  input wire [3:0] opcode,
  input wire bit_in,
  // results
  input wire [7:0] acc,
  input wire carry,
  input wire busy,
  input wire done,
  input wire [1:0] length,
  input wire branch_taken,
  input wire bit_we,
  input wire bit_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a start during busy is dropped, so only these count
  wire go = start && !busy;
  // two-cycle retire: busy first, then done with busy low
  sequence s_two;
    busy && !done ##1 done && !busy;
  endsequence
  property p_add;
    go && opcode == `BAEU_OP_ADD_C_IMM |=> done && length == `BAEU_LEN_TWO;
  endproperty
  a_add: assert property (p_add) else $error("add timing");
  property p_ror;
    go && opcode == `BAEU_OP_ROR_C |=>
      {acc, carry} == {$past(carry), $past(acc)};
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right");
  property p_rol;
    go && opcode == `BAEU_OP_ROL_C |=>
      {carry, acc} == {$past(acc), $past(carry)};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left");
  property p_cset;
    go && opcode == `BAEU_OP_C_ONE |=> carry && done;
  endproperty
  a_cset: assert property (p_cset) else $error("carry set");
  property p_cmp;
    go && opcode == `BAEU_OP_CMP_BNE |=> s_two;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare timing");
  property p_jclr;
    go && opcode == `BAEU_OP_JMP_HI_ZERO && bit_in |=>
      s_two ##0 bit_we && !bit_out && branch_taken;
  endproperty
  a_jclr: assert property (p_jclr) else $error("jump then clear");
  property p_jhi;
    go && opcode == `BAEU_OP_JMP_HI |=>
      !bit_we ##1 !bit_we && branch_taken == $past(bit_in, 2);
  endproperty
  a_jhi: assert property (p_jhi) else $error("jump on high");
  property p_inv;
    go && opcode == `BAEU_OP_BIT_INV |=> bit_we && bit_out == !$past(bit_in);
  endproperty
  a_inv: assert property (p_inv) else $error("bit invert");
endmodule // baeu_exec_props
bind baeu_exec baeu_exec_props u_baeu_exec_props (.mclk, .rst_n, .start,
  .opcode, .bit_in, .acc, .carry, .busy, .done, .length, .branch_taken,
  .bit_we, .bit_out);

// ### verif/baeu_exec_tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
`include "baeu_consts.vh"
module baeu_exec_tb_top;
  reg mclk = 0, rst_n = 0, start = 0, bit_in = 0;
  reg [3:0] opcode = 0;
  reg [1:0] move_mode = 0;
  reg [7:0] operand = 0, rel = 0, cmp_imm = 0;
  reg [15:0] pc_in = 16'h1000;
  wire [7:0] acc;
  wire [1:0] length;
  wire [15:0] pc_next;
  wire carry, busy, done, branch_taken, bit_we, bit_out;
  integer err_total = 0, check_count = 0, n, i;
  reg we, bo, bt;
  ////////////////////////////////////////////////////////////////////////
  baeu_exec u_baeu_exec (.mclk, .rst_n, .start, .opcode, .move_mode,
    .operand, .rel, .cmp_imm, .pc_in, .bit_in, .acc, .carry, .busy, .done,
    .length, .pc_next, .branch_taken, .bit_we, .bit_out);
  // 125 mhz core clock
  always #4 mclk = ~mclk;
  // compare and count; wide enough for packed flag groups
  task chk(input string nm, input [23:0] seen, input [23:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one instruction; n ends as cycles to done, bounded so a hang shows
  // for compare, od is the ram byte, ci the immediate, rl the offset
  task run(input [3:0] op, input [7:0] od = 0, input [7:0] rl = 0,
      input b = 0, input [1:0] mv = 0, input [7:0] ci = 0);
    @(posedge mclk);
    #1 {opcode, operand, rel, bit_in, move_mode} = {op, od, rl, b, mv};
    cmp_imm = ci;
    start = 1;
    @(posedge mclk);
    #1 start = 0;
    for (n = 1; n < 4 && done !== 1'b1; n = n + 1) begin
      @(posedge mclk);
      #1;
    end
    {we, bo, bt} = {bit_we, bit_out, branch_taken};
  endtask
  ////////////////////////////////////////////////////////////////////////
  // plain add must ignore a set carry; with carry and borrow use it
  task t_arith;
    run(`BAEU_OP_C_ONE);
    run(`BAEU_OP_ADD_IMM, 8'hf0);
    chk("add", {n[1:0], length, carry, acc},
        {2'h1, `BAEU_LEN_TWO, 9'h0f0});
    run(`BAEU_OP_C_ONE);
    run(`BAEU_OP_ADD_C_IMM, 8'h0f);
    chk("add carry", {carry, acc}, 9'h100);
    run(`BAEU_OP_SUB_IND, 8'h01);
    chk("sub borrow", {n[1:0], length, carry, acc},
        {2'h1, `BAEU_LEN_ONE, 9'h1fe});
    run(`BAEU_OP_ROR_C);
    chk("ror", {n[1:0], carry, acc}, {2'h1, 9'h0ff});
    run(`BAEU_OP_ROL_C);
    chk("rol", {carry, acc}, 9'h1fe);
    $display("arith test ended");
  endtask
  // set, clear, invert on a set bit, then invert on a clear bit, carry clear and carry invert
  task t_bits;
    for (i = 0; i < 3; i = i + 1) begin
      run(4'(`BAEU_OP_BIT_ONE + i), 0, 0, 1);
      chk("bit op", {we, bo}, {1'h1, i == 0});
    end
    run(`BAEU_OP_BIT_INV, 0, 0, 0);
    chk("bit inv low", {we, bo}, 2'h3);
    run(`BAEU_OP_C_ZERO);
    chk("c zero", carry, 0);
    run(`BAEU_OP_C_INV);
    chk("c inv", carry, 1);
    $display("bit test ended");
  endtask
  // extreme displacements, both outcomes, test-and-clear
  task t_jump;
    run(`BAEU_OP_JMP_HI, 0, 8'h80, 1);
    chk("jh", {n[1:0], length, bt, we}, {2'h2, `BAEU_LEN_THREE, 2'h2});
    chk("jh pc", pc_next, 16'h0f83);
    run(`BAEU_OP_JMP_LO, 0, 8'h80, 1);
    chk("jl", {bt, pc_next}, {1'h0, 16'h1003});
    run(`BAEU_OP_JMP_HI_ZERO, 0, 8'h7f, 1);
    chk("jc", {bt, we, bo, pc_next}, {3'h6, 16'h1082});
    run(`BAEU_OP_JMP_HI_ZERO, 0, 8'h7f, 0);
    chk("jc low", {bt, we}, 2'h0);
    run(`BAEU_OP_CMP_BNE, 8'h04, 8'h10, 0, 0, 8'h05);
    chk("cmp", {n[1:0], bt, carry, pc_next}, {4'hb, 16'h1013});
    run(`BAEU_OP_CMP_BNE, 8'h06, 8'hfe, 0, 0, 8'h05);
    chk("cmp gt", {bt, carry, pc_next}, {2'h2, 16'h1001});
    run(`BAEU_OP_CMP_BNE, 8'h05, 8'h10, 0, 0, 8'h05);
    chk("cmp eq", {bt, carry, pc_next}, {2'h0, 16'h1003});
    $display("jump test ended");
  endtask
  // bit to carry in one cycle, carry back out in two
  task t_move;
    run(`BAEU_OP_NOP, 0, 0, 1, `BAEU_MV_TO_C);
    chk("to c", {n[1:0], carry}, 3'h3);
    run(`BAEU_OP_NOP, 0, 0, 0, `BAEU_MV_FROM_C);
    chk("from c", {n[1:0], we, bo}, 4'hb);
    $display("move test ended");
  endtask
  // counts, verdict and stop
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // reset for 12 cycles, then the tests
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst_n = 1;
    t_arith;
    t_bits;
    t_jump;
    t_move;
    end_sim;
  end
  // watchdog: the tests need well under 200 cycles
  initial begin
    #20000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // baeu_exec_tb_top
